// ==== src/maf_pkg.sv ====
// maf_pkg: register map, field layout and timing for the address filter,
// transmit pause timer and transmit head pointer block.
// assumes a 32-bit APB register bus and a 100 MHz system clock.
package maf_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_TX_PAUSE   = 8'h00;
    localparam logic [7:0] OFF_ADDR_LO    = 8'h04;
    localparam logic [7:0] OFF_ADDR_HI    = 8'h08;
    localparam logic [7:0] OFF_SLOT_SEL   = 8'h0c;
    localparam logic [7:0] OFF_HOST_ERR   = 8'h10;
    localparam logic [7:0] OFF_TX_HDP0    = 8'h20;
    localparam logic [7:0] OFF_TX_HDP_END = 8'h3c;

    // low address word fields
    localparam int LO_VALID_BIT = 20;
    localparam int LO_MFILT_BIT = 19;
    localparam int LO_CHAN_LSB  = 16;
    localparam int LO_BYTE0_LSB = 8;
    localparam int LO_BYTE1_LSB = 0;
    // high address word fields
    localparam int HI_BYTE2_LSB = 24;
    localparam int HI_BYTE3_LSB = 16;
    localparam int HI_BYTE4_LSB = 8;
    localparam int HI_BYTE5_LSB = 0;
    // slot select and host error fields
    localparam int SEL_W        = 5;
    localparam int ERR_FLAG_BIT = 0;
    localparam int ERR_CHAN_LSB = 8;

    // reset values
    localparam logic [31:0] RST_ADDR_HI = 32'h0000_0000;
    localparam logic [31:0] RST_ADDR_LO = 32'h0000_0000;
    localparam logic [15:0] RST_PAUSE   = 16'h0000;
    localparam logic [31:0] RST_HDP     = 32'h0000_0000;

    // table geometry
    localparam int TBL_DEPTH = 32;
    localparam int CHAN_W    = 3;
    localparam int ENTRY_W   = 53;
    localparam int N_TXQ     = 8;

    // slot time: 512 bit times at 100 Mbit/s
    localparam int CLK_PERIOD_NS = 10;
    localparam int SLOT_TIME_NS  = 5120;
    localparam int SLOT_CYC      = SLOT_TIME_NS / CLK_PERIOD_NS;
endpackage

// ==== src/maf_slot_cmp.sv ====
// maf_slot_cmp: compares one address table entry against an incoming
// destination address. assumes the entry and address are stable inputs.
`timescale 1ns/1ps
module maf_slot_cmp (
    // table entry
    input  wire logic        valid,
    input  wire logic        mfilt,
    input  wire logic [47:0] addr,
    // incoming destination address
    input  wire logic [47:0] da,
    // hit results
    output logic             hit_match,
    output logic             hit_reject
);
    wire same = (addr == da);

    // invalid entries take no part in the decision
    assign hit_match  = valid & mfilt & same;
    assign hit_reject = valid & ~mfilt & same;
endmodule

// ==== src/maf_top.sv ====
// maf_top: APB register slave with transmit pause timer, 32-entry receive
// address table with match/reject lookup, and eight transmit head pointers.
// assumes pause frames and destination addresses arrive already parsed.
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps

module maf_top
    import maf_pkg::*;
#(
    parameter int SLOT_CYCLES = maf_pkg::SLOT_CYC
) (
    // clock and reset
    input  wire logic                       CLK,
    input  wire logic                       RST_B,
    // apb slave
    input  wire logic                       PSEL,
    input  wire logic                       PENABLE,
    input  wire logic                       PWRITE,
    input  wire logic [7:0]                 PADDR,
    input  wire logic [31:0]                PWDATA,
    output logic      [31:0]                PRDATA,
    output logic                            PREADY,
    output logic                            PSLVERR,
    // received pause frames
    input  wire logic                       RX_PAUSE_VALID,
    input  wire logic [15:0]                RX_PAUSE_TIME,
    output logic                            TX_HOLD,
    // destination address lookup
    input  wire logic                       RX_DA_VALID,
    input  wire logic [47:0]                RX_DA,
    output logic                            RX_DEC_VALID,
    output logic                            RX_MATCH,
    output logic                            RX_DISCARD,
    output logic      [maf_pkg::CHAN_W-1:0] RX_CHANNEL,
    // transmit queues
    input  wire logic [maf_pkg::N_TXQ-1:0]  TX_HDP_CLR,
    output logic      [maf_pkg::N_TXQ-1:0]  TX_START,
    output logic      [31:0]                TX_START_ADDR,
    output logic                            HOST_ERR
);
    import maf_pkg::*;

    // apb decode
    wire        acc     = PSEL & PENABLE;
    wire        setup   = PSEL & ~PENABLE;
    wire        wr      = acc & PWRITE;
    wire        hit_pau = (PADDR == OFF_TX_PAUSE);
    wire        hit_lo  = (PADDR == OFF_ADDR_LO);
    wire        hit_hi  = (PADDR == OFF_ADDR_HI);
    wire        hit_sel = (PADDR == OFF_SLOT_SEL);
    wire        hit_err = (PADDR == OFF_HOST_ERR);
    wire        hit_hdp = (PADDR >= OFF_TX_HDP0) && (PADDR <= OFF_TX_HDP_END)
                          && (PADDR[1:0] == 2'b00);
    wire [2:0]  hdp_ch  = 3'(PADDR[4:2]);
    wire        mapped  = hit_pau | hit_lo | hit_hi | hit_sel | hit_err
                          | hit_hdp;
    wire        wr_lo   = wr & hit_lo;
    wire        wr_hi   = wr & hit_hi;
    wire        wr_sel  = wr & hit_sel;
    wire        wr_err  = wr & hit_err;
    wire        wr_hdp  = wr & hit_hdp;

    assign PREADY  = 1'b1;
    assign PSLVERR = acc & ~mapped;

    // state
    logic [15:0]          pause_r;
    logic [15:0]          slot_cnt_r;
    logic                 slot_tick;
    logic [31:0]          lo_r;
    logic [31:0]          hi_r;
    logic [SEL_W-1:0]     sel_r;
    logic [ENTRY_W-1:0]   tbl [TBL_DEPTH];
    logic [31:0]          hdp_r [N_TXQ];
    logic                 err_r;
    logic [2:0]           err_ch_r;
    logic [31:0]          prdata_r;
    logic [N_TXQ-1:0]     start_r;
    logic [31:0]          start_addr_r;
    logic                 dec_v_r;
    logic                 match_r;
    logic                 disc_r;
    logic [CHAN_W-1:0]    chan_r;

    // slot time divider
    assign slot_tick = (slot_cnt_r == 16'(SLOT_CYCLES - 1));
    always_ff @(posedge CLK) begin
        if (!RST_B || slot_tick)
            slot_cnt_r <= 16'h0000;
        else
            slot_cnt_r <= slot_cnt_r + 16'h0001;
    end

    // transmit pause counter, a new pause frame overrides the count
    wire [15:0] pause_nxt = RX_PAUSE_VALID ? RX_PAUSE_TIME :
                            (slot_tick && pause_r != 16'h0000) ?
                            pause_r - 16'h0001 : pause_r;
    always_ff @(posedge CLK) begin
        if (!RST_B)
            pause_r <= RST_PAUSE;
        else
            pause_r <= pause_nxt;
    end
    assign TX_HOLD = (pause_r != 16'h0000);

    // staged address words and slot select
    wire [47:0] new_addr = {hi_r[HI_BYTE5_LSB +: 8],
                            hi_r[HI_BYTE4_LSB +: 8],
                            hi_r[HI_BYTE3_LSB +: 8],
                            hi_r[HI_BYTE2_LSB +: 8],
                            PWDATA[LO_BYTE1_LSB +: 8],
                            PWDATA[LO_BYTE0_LSB +: 8]};
    wire [ENTRY_W-1:0] new_entry = {PWDATA[LO_VALID_BIT],
                                    PWDATA[LO_MFILT_BIT],
                                    PWDATA[LO_CHAN_LSB +: CHAN_W],
                                    new_addr};
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            lo_r  <= RST_ADDR_LO;
            hi_r  <= RST_ADDR_HI;
            sel_r <= '0;
        end else begin
            if (wr_lo)
                lo_r <= PWDATA & 32'h001f_ffff;
            if (wr_hi)
                hi_r <= PWDATA;
            if (wr_sel)
                sel_r <= PWDATA[SEL_W-1:0];
        end
    end

    // table commit on low word only; the high word just stages
    always_ff @(posedge CLK) begin
        if (wr_lo)
            tbl[sel_r] <= new_entry;
    end

    // per-entry compare
    logic [TBL_DEPTH-1:0] hm;
    logic [TBL_DEPTH-1:0] hr;
    logic [TBL_DEPTH-1:0] cand;
    genvar g;
    generate
        for (g = 0; g < TBL_DEPTH; g++) begin : g_cmp
            // valid entry holding this address, apart from the comparator
            assign cand[g] = tbl[g][ENTRY_W-1] & (tbl[g][47:0] == RX_DA);
            maf_slot_cmp u_cmp (
                .valid      (tbl[g][ENTRY_W-1]),
                .mfilt      (tbl[g][ENTRY_W-2]),
                .addr       (tbl[g][47:0]),
                .da         (RX_DA),
                .hit_match  (hm[g]),
                .hit_reject (hr[g])
            );
        end
    endgenerate

    // lowest matching entry supplies the channel
    logic [CHAN_W-1:0] first_ch;
    always_comb begin
        first_ch = '0;
        for (int i = TBL_DEPTH - 1; i >= 0; i--) begin
            if (hm[i])
                first_ch = tbl[i][48 +: CHAN_W];
        end
    end
    wire any_rej = |hr;
    wire any_mat = |hm;

    // registered decision, reject wins over match
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            dec_v_r <= 1'b0;
            match_r <= 1'b0;
            disc_r  <= 1'b0;
            chan_r  <= '0;
        end else begin
            dec_v_r <= RX_DA_VALID;
            if (RX_DA_VALID) begin
                disc_r  <= any_rej;
                match_r <= any_mat & ~any_rej;
                chan_r  <= any_rej ? '0 : first_ch;
            end
        end
    end
    assign RX_DEC_VALID = dec_v_r;
    assign RX_MATCH     = match_r;
    assign RX_DISCARD   = disc_r;
    assign RX_CHANNEL   = chan_r;

    // transmit head pointers
    wire hdp_busy = (hdp_r[hdp_ch] != 32'h0000_0000);
    wire bad_wr   = wr_hdp & hdp_busy;
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            for (int q = 0; q < N_TXQ; q++)
                hdp_r[q] <= RST_HDP;
            start_r      <= '0;
            start_addr_r <= 32'h0000_0000;
        end else begin
            start_r <= '0;
            for (int q = 0; q < N_TXQ; q++) begin
                if (TX_HDP_CLR[q])
                    hdp_r[q] <= 32'h0000_0000;
            end
            if (wr_hdp && !hdp_busy && PWDATA != 32'h0000_0000) begin
                hdp_r[hdp_ch]   <= PWDATA;
                start_r[hdp_ch] <= 1'b1;
                start_addr_r    <= PWDATA;
            end
        end
    end
    assign TX_START      = start_r;
    assign TX_START_ADDR = start_addr_r;

    // host error flag, write one to clear, a new error wins
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            err_r    <= 1'b0;
            err_ch_r <= 3'h0;
        end else if (bad_wr) begin
            err_r    <= 1'b1;
            err_ch_r <= hdp_ch;
        end else if (wr_err && PWDATA[ERR_FLAG_BIT]) begin
            err_r    <= 1'b0;
        end
    end
    assign HOST_ERR = err_r;

    // read data captured in the setup phase
    wire [31:0] rd_mux =
        hit_pau ? {16'h0000, pause_r} :
        hit_lo  ? lo_r :
        hit_hi  ? hi_r :
        hit_sel ? {27'h0, sel_r} :
        hit_err ? {21'h0, err_ch_r, 7'h0, err_r} :
        hit_hdp ? hdp_r[hdp_ch] : 32'h0000_0000;
    always_ff @(posedge CLK) begin
        if (!RST_B)
            prdata_r <= 32'h0000_0000;
        else if (setup && !PWRITE)
            prdata_r <= rd_mux;
    end
    assign PRDATA = prdata_r;

    // entries written since reset, so checks skip undefined slots
    logic [TBL_DEPTH-1:0] written_r;
    always_ff @(posedge CLK) begin
        if (!RST_B)
            written_r <= '0;
        else if (wr_lo)
            written_r[sel_r] <= 1'b1;
    end

    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    property p_pause_load;
        RX_PAUSE_VALID |=> pause_r == $past(RX_PAUSE_TIME);
    endproperty
    a_pause_load: assert property (p_pause_load)
        else $error("pause counter not loaded");

    property p_pause_dec;
        !RX_PAUSE_VALID && slot_tick && TX_HOLD
            |=> pause_r == $past(pause_r) - 16'h0001;
    endproperty
    a_pause_dec: assert property (p_pause_dec)
        else $error("pause counter did not step down");

    property p_hold_release;
        !TX_HOLD && !RX_PAUSE_VALID |=> !TX_HOLD;
    endproperty
    a_hold_release: assert property (p_hold_release)
        else $error("hold asserted without pause frame");

    property p_pause_read;
        setup && !PWRITE && hit_pau
            |=> PRDATA == {16'h0000, $past(pause_r)};
    endproperty
    a_pause_read: assert property (p_pause_read)
        else $error("pause read value wrong");

    property p_no_valid;
        RX_DA_VALID && cand == '0
            |=> RX_DEC_VALID && !RX_MATCH && !RX_DISCARD
                && RX_CHANNEL == '0;
    endproperty
    a_no_valid: assert property (p_no_valid)
        else $error("decision made with no valid entry");

    property p_reject;
        RX_DA_VALID && any_rej |=> RX_DISCARD && !RX_MATCH;
    endproperty
    a_reject: assert property (p_reject)
        else $error("reject hit not discarded");

    property p_match;
        RX_DA_VALID && any_mat && !any_rej
            |=> RX_MATCH && RX_CHANNEL == $past(first_ch);
    endproperty
    a_match: assert property (p_match)
        else $error("match hit not accepted on its channel");

    property p_commit;
        wr_lo |=> tbl[$past(sel_r)] == $past(new_entry);
    endproperty
    a_commit: assert property (p_commit)
        else $error("entry not committed on low word write");

    property p_hi_stage;
        wr_hi && written_r[sel_r] |=> tbl[sel_r] == $past(tbl[sel_r]);
    endproperty
    a_hi_stage: assert property (p_hi_stage)
        else $error("high word write altered the table");

    property p_sel;
        wr_sel |=> sel_r == $past(PWDATA[SEL_W-1:0]);
    endproperty
    a_sel: assert property (p_sel)
        else $error("slot select not updated");

    property p_start;
        wr_hdp && !hdp_busy && PWDATA != 32'h0
            |=> TX_START == $past(8'h01 << hdp_ch) ##1 TX_START == '0;
    endproperty
    a_start: assert property (p_start)
        else $error("queue start pulse wrong");

    property p_bad_wr;
        bad_wr |=> HOST_ERR && TX_START == '0;
    endproperty
    a_bad_wr: assert property (p_bad_wr)
        else $error("busy head pointer write not flagged");

    c_pause: cover property (RX_PAUSE_VALID ##1 TX_HOLD);
    c_match: cover property (RX_DEC_VALID && RX_MATCH);
    c_disc:  cover property (RX_DEC_VALID && RX_DISCARD);
    c_start: cover property (TX_START != '0);
    c_err:   cover property (bad_wr);
endmodule

// ==== tb/maf_link_model.sv ====
// maf_link_model: far side of the network link, handing over parsed
// pause frames and destination addresses. assumes tasks called by tb.
`timescale 1ns/1ps
module maf_link_model (
    // clock
    input  wire logic   CLK,
    // parsed receive traffic
    output logic        RX_PAUSE_VALID,
    output logic [15:0] RX_PAUSE_TIME,
    output logic        RX_DA_VALID,
    output logic [47:0] RX_DA
);
    initial begin
        RX_PAUSE_VALID = 1'b0;
        RX_PAUSE_TIME  = 16'h0000;
        RX_DA_VALID    = 1'b0;
        RX_DA          = 48'h0;
    end
    // released fields go to the inverse of the last value
    task automatic send_pause(input logic [15:0] t);
        @(posedge CLK);
        RX_PAUSE_VALID <= 1'b1;
        RX_PAUSE_TIME  <= t;
        @(posedge CLK);
        RX_PAUSE_VALID <= 1'b0;
        RX_PAUSE_TIME  <= ~t;
    endtask
    task automatic send_da(input logic [47:0] a);
        @(posedge CLK);
        RX_DA_VALID <= 1'b1;
        RX_DA       <= a;
        @(posedge CLK);
        RX_DA_VALID <= 1'b0;
        RX_DA       <= ~a;
    endtask
endmodule

// ==== tb/tb.sv ====
// tb: drives maf_top over apb and through the link model; self-checking.
// assumes a 100 MHz clock and a shortened slot time.
`timescale 1ns/1ps
module tb;
    import maf_pkg::*;
    localparam int SLOT = 4;
    logic        clk;
    logic        rst_b;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pv;
    logic [15:0] pt;
    logic        tx_hold;
    logic        dv;
    logic [47:0] da;
    logic        dec_v;
    logic        match;
    logic        disc;
    logic [2:0]  chan;
    logic [7:0]  hdp_clr;
    logic [7:0]  tx_start;
    logic [31:0] tx_addr;
    logic        host_err;
    logic [31:0] rd;
    logic        serr;
    logic [7:0]  a;
    int          error_cnt = 0;
    int          check_count = 0;
    int          n;
    localparam logic [47:0] AA = 48'h0a0b0c0d0e0f;
    localparam logic [47:0] BB = 48'h112233445566;
    localparam logic [47:0] CC = 48'h778899aabbcc;
    localparam logic [47:0] DD = 48'hfedcba987654;

    maf_top #(.SLOT_CYCLES(SLOT)) i_maf_top (
        .CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .RX_PAUSE_VALID(pv),
        .RX_PAUSE_TIME(pt), .TX_HOLD(tx_hold), .RX_DA_VALID(dv),
        .RX_DA(da), .RX_DEC_VALID(dec_v), .RX_MATCH(match),
        .RX_DISCARD(disc), .RX_CHANNEL(chan), .TX_HDP_CLR(hdp_clr),
        .TX_START(tx_start), .TX_START_ADDR(tx_addr), .HOST_ERR(host_err)
    );
    maf_link_model i_maf_link_model (
        .CLK(clk), .RX_PAUSE_VALID(pv), .RX_PAUSE_TIME(pt),
        .RX_DA_VALID(dv), .RX_DA(da)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic report_and_stop;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one apb transfer; read data and error taken at the ready edge
    task automatic apb(input logic w, input logic [7:0] ad,
                       input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= ad;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        serr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic set_entry(input logic [4:0] i, input logic [47:0] ad,
                             input logic [4:0] ctl, input logic lo);
        apb(1'b1, OFF_SLOT_SEL, {27'h0, i});
        apb(1'b1, OFF_ADDR_HI,
            {ad[23:16], ad[31:24], ad[39:32], ad[47:40]});
        if (lo)
            apb(1'b1, OFF_ADDR_LO,
                {11'h0, ctl, ad[7:0], ad[15:8]});
    endtask

    // expected is {match, discard, channel}
    task automatic look(input logic [47:0] ad, input logic [4:0] e);
        i_maf_link_model.send_da(ad);
        #1;
        chk("dec_valid", 32'h1, 32'(dec_v));
        chk("decision", 32'(e), {27'h0, match, disc, chan});
    endtask

    initial begin
        #300000;
        error_cnt++;
        report_and_stop;
    end

    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        hdp_clr = 8'h00;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        apb(1'b1, OFF_TX_PAUSE, 32'hffffffff);
        apb(1'b0, OFF_TX_PAUSE, 32'h0);
        chk("pause_ro", 32'h0, rd);
        chk("hold_rst", 32'h0, 32'(tx_hold));
        chk("err_rst", 32'h0, 32'(host_err));
        apb(1'b0, 8'h14, 32'h0);
        chk("slverr", 32'h1, 32'(serr));
        chk("unmapped", 32'h0, rd);
        for (int i = 0; i < 32; i++)
            set_entry(5'(i), 48'h0, 5'h00, 1'b1);
        set_entry(5'd3, AA, 5'h1d, 1'b1);
        set_entry(5'd7, BB, 5'h16, 1'b1);
        set_entry(5'd10, BB, 5'h1a, 1'b1);
        set_entry(5'd9, CC, 5'h0a, 1'b1);
        set_entry(5'd31, DD, 5'h1f, 1'b1);
        look(AA, 5'h15);
        look(BB, 5'h08);
        look(CC, 5'h00);
        look(48'h0, 5'h00);
        look(DD, 5'h17);
        set_entry(5'd3, CC, 5'h19, 1'b0);
        look(AA, 5'h15);
        apb(1'b1, OFF_ADDR_LO, {11'h0, 5'h19, CC[7:0], CC[15:8]});
        look(CC, 5'h11);
        look(AA, 5'h00);
        apb(1'b0, OFF_ADDR_HI, 32'h0);
        chk("hi_rd", {CC[23:16], CC[31:24], CC[39:32], CC[47:40]},
            rd);
        apb(1'b0, OFF_ADDR_LO, 32'h0);
        chk("lo_rd", {11'h0, 5'h19, CC[7:0], CC[15:8]}, rd);
        i_maf_link_model.send_pause(16'hffff);
        #1;
        chk("hold_on", 32'h1, 32'(tx_hold));
        apb(1'b0, OFF_TX_PAUSE, 32'h0);
        chk("pause_top", 32'h0, 32'(rd[31:16]));
        chk("pause_ld", 32'h1, 32'(rd[15:0] > 16'hfff8));
        i_maf_link_model.send_pause(16'h0002);
        n = 0;
        #1;
        while (tx_hold === 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("pause_len", 32'h1, 32'(n >= 5 && n <= 8));
        apb(1'b0, OFF_TX_PAUSE, 32'h0);
        chk("pause_end", 32'h0, rd);
        for (int c = 0; c < N_TXQ; c++) begin
            a = OFF_TX_HDP0 + 8'(4 * c);
            apb(1'b1, a, 32'h0);
            #1;
            chk("start_none", 32'h0, 32'(tx_start));
            apb(1'b1, a, 32'h10000000 + 32'(16 * c));
            #1;
            chk("start", 32'(8'h01 << c), 32'(tx_start));
            chk("start_addr", 32'h10000000 + 32'(16 * c), tx_addr);
            apb(1'b1, a, 32'hdead0000);
            #1;
            chk("err_set", 32'h1, 32'(host_err));
            chk("no_restart", 32'h0, 32'(tx_start));
            apb(1'b0, OFF_HOST_ERR, 32'h0);
            chk("err_reg", 32'h1 | 32'(c << 8), rd);
            apb(1'b0, a, 32'h0);
            chk("hdp_kept", 32'h10000000 + 32'(16 * c), rd);
            apb(1'b1, OFF_HOST_ERR, 32'h1);
            #1;
            chk("err_clr", 32'h0, 32'(host_err));
            @(posedge clk);
            hdp_clr <= 8'h01 << c;
            @(posedge clk);
            hdp_clr <= 8'h00;
            apb(1'b0, a, 32'h0);
            chk("hdp_zero", 32'h0, rd);
        end
        report_and_stop;
    end
endmodule
